/* rtl/mdfm_cfg.svh */
// constants of the motor driver fault manager
`ifndef MDFM_CFG_SVH
`define MDFM_CFG_SVH

// register bus
`define MDFM_AW 4
`define MDFM_DW 16
`define MDFM_ADDR_STATUS 4'h0
`define MDFM_ADDR_CTRL 4'h4
`define MDFM_ADDR_LIVE 4'h8

// status register bits
`define MDFM_ST_FAULT 0
`define MDFM_ST_POR 1
`define MDFM_ST_BK_SUM 2
`define MDFM_ST_BK_UV 3
`define MDFM_ST_CP_UV 4
`define MDFM_ST_OV 5
`define MDFM_ST_OC 6
`define MDFM_ST_BK_OC 7
`define MDFM_ST_SER 8
`define MDFM_ST_TW 9
`define MDFM_ST_TS 10
`define MDFM_ST_TRIM 11

// control register bits
`define MDFM_CT_OV_EN 0
`define MDFM_CT_OV_SEL 1
`define MDFM_CT_OCM_LO 2
`define MDFM_CT_OCM_HI 3
`define MDFM_CT_SER_REP 4
`define MDFM_CT_TW_REP 5
`define MDFM_CT_CLR 6

// live condition bits, order of the synchroniser bundle
`define MDFM_NSYNC 13
`define MDFM_LV_MOT_UV 0
`define MDFM_LV_ANA_UV 1
`define MDFM_LV_BK_UV 2
`define MDFM_LV_CP_UV 3
`define MDFM_LV_OV_LO 4
`define MDFM_LV_OV_HI 5
`define MDFM_LV_OC 6
`define MDFM_LV_BK_OC 7
`define MDFM_LV_TW 8
`define MDFM_LV_TSD_FET 9
`define MDFM_LV_TSD_DIE 10
`define MDFM_LV_SLEEP_N 11
`define MDFM_LV_HW_VAR 12

// reset value of the control register and overcurrent mode codes
`define MDFM_CTRL_RST 16'h0000
`define MDFM_OCM_LATCH 2'h0
`define MDFM_OCM_RETRY 2'h1
`define MDFM_OCM_REPORT 2'h2
`define MDFM_OCM_OFF 2'h3

// timing
`define MDFM_CLK_NS 25
`define MDFM_T_OC_DEG_NS 600
`define MDFM_T_BK_DEG_NS 600
`define MDFM_T_RST_NS 1000
`define MDFM_T_RETRY_NS 5000000
`define MDFM_T_BK_RETRY_NS 5000000
`define MDFM_CYC_MIN(t) (((t) + `MDFM_CLK_NS - 1) / `MDFM_CLK_NS)
`define MDFM_CNT_W 24

`endif

/* rtl/mdfm_pkg.sv */
// types of the motor driver fault manager
`include "mdfm_cfg.svh"
package mdfm_pkg;

	typedef logic [`MDFM_AW-1:0] mdfm_addr_t;
	typedef logic [`MDFM_DW-1:0] mdfm_data_t;
	typedef logic [`MDFM_CNT_W-1:0] mdfm_cnt_t;

	typedef enum logic [1:0] {
		MDFM_OC_IDLE = 2'h0,
		MDFM_OC_LATCH = 2'h1,
		MDFM_OC_RETRY = 2'h2,
		MDFM_OC_REPORT = 2'h3
	} mdfm_oc_state_t;

endpackage

/* rtl/mdfm_sync.sv */
// two-stage synchroniser for a bundle of levels
`timescale 1ns/1ps
module mdfm_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// levels
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} mdfm_sync_st_t;

	mdfm_sync_st_t s_r;
	mdfm_sync_st_t s_nxt;

	always_comb begin
		s_nxt.meta = i_async;
		s_nxt.sync = s_r.meta;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_sync = s_r.sync;
endmodule

/* rtl/mdfm_deglitch.sv */
// level qualifier: output rises after the input held high n cycles
`timescale 1ns/1ps
module mdfm_deglitch #(
	parameter int N = 24
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// level in and qualified level out
	input wire logic i_level,
	output logic o_level
);
	import mdfm_pkg::*;

	localparam mdfm_cnt_t LAST = mdfm_cnt_t'(N - 1);

	typedef struct packed {
		mdfm_cnt_t cnt;
		logic q;
	} mdfm_dg_st_t;

	mdfm_dg_st_t s_r;
	mdfm_dg_st_t s_nxt;

	// drop is immediate: a release must never be delayed
	always_comb begin
		s_nxt = s_r;
		if (!i_level) begin
			s_nxt.cnt = '0;
			s_nxt.q = 1'b0;
		end else if (s_r.cnt == LAST) begin
			s_nxt.q = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + mdfm_cnt_t'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_level = s_r.q;
endmodule

/* rtl/mdfm_top.sv */
// fault manager of a three-phase motor driver
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "mdfm_cfg.svh"

module mdfm_top #(
	parameter int OC_DEG_CYC = `MDFM_CYC_MIN(`MDFM_T_OC_DEG_NS),
	parameter int BK_DEG_CYC = `MDFM_CYC_MIN(`MDFM_T_BK_DEG_NS),
	parameter int RST_CYC = `MDFM_CYC_MIN(`MDFM_T_RST_NS),
	parameter int RETRY_CYC = `MDFM_CYC_MIN(`MDFM_T_RETRY_NS),
	parameter int BK_RETRY_CYC = `MDFM_CYC_MIN(`MDFM_T_BK_RETRY_NS)
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// register port
	input wire mdfm_pkg::mdfm_addr_t i_addr,
	input wire mdfm_pkg::mdfm_data_t i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output mdfm_pkg::mdfm_data_t o_rdata,
	// condition inputs from comparators and pins
	input wire logic i_motor_supply_uv,
	input wire logic i_analog_rail_uv,
	input wire logic i_buck_undervolt_flag,
	input wire logic i_pump_output_uv,
	input wire logic i_overvolt_low_trip,
	input wire logic i_overvolt_high_trip,
	input wire logic i_phase_overcurrent,
	input wire logic i_buck_overcurrent,
	input wire logic i_fet_area_thermal_shutdown,
	input wire logic i_die_thermal_shutdown,
	input wire logic i_thermal_warning,
	input wire logic i_sleep_pin_n,
	input wire logic i_hw_variant,
	// same-clock event pulses
	input wire logic i_serial_error,
	input wire logic i_trim_error,
	// outputs
	output logic o_fault_pin_n,
	output logic o_bridge_hiz,
	output logic o_pump_en,
	output logic o_logic_en,
	output logic o_buck_en
);
	import mdfm_pkg::*;

	localparam mdfm_cnt_t RETRY_LAST = mdfm_cnt_t'(RETRY_CYC - 1);
	localparam mdfm_cnt_t BK_RETRY_LAST = mdfm_cnt_t'(BK_RETRY_CYC - 1);

	// *****************************
	// state
	// *****************************
	typedef struct packed {
		logic ov_en;
		logic ov_sel;
		logic [1:0] ocm;
		logic ser_rep;
		logic tw_rep;
		logic f_fault;
		logic f_por;
		logic f_bk_sum;
		logic f_bk_uv;
		logic f_cp_uv;
		logic f_ov;
		logic f_oc;
		logic f_bk_oc;
		logic f_ser;
		logic f_tw;
		logic f_ts;
		logic f_trim;
		mdfm_oc_state_t oc_st;
		mdfm_cnt_t oc_cnt;
		logic bk_act;
		mdfm_cnt_t bk_cnt;
		logic sl_long_q;
		mdfm_data_t rdata;
		logic fault_n;
		logic bridge_hiz;
		logic pump_en;
		logic logic_en;
		logic buck_en;
	} mdfm_st_t;

	mdfm_st_t s_r;
	mdfm_st_t s_nxt;

	// *****************************
	// input conditioning
	// *****************************
	logic [`MDFM_NSYNC-1:0] lv;
	logic oc_dg;
	logic bk_dg;
	logic sl_long;

	mdfm_sync #(
		.W(`MDFM_NSYNC)
	) u_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async({i_hw_variant, i_sleep_pin_n, i_die_thermal_shutdown,
			i_fet_area_thermal_shutdown, i_thermal_warning,
			i_buck_overcurrent, i_phase_overcurrent,
			i_overvolt_high_trip, i_overvolt_low_trip,
			i_pump_output_uv, i_buck_undervolt_flag, i_analog_rail_uv,
			i_motor_supply_uv}),
		.o_sync(lv)
	);

	mdfm_deglitch #(
		.N(OC_DEG_CYC)
	) u_oc_dg (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_level(lv[`MDFM_LV_OC]),
		.o_level(oc_dg)
	);

	mdfm_deglitch #(
		.N(BK_DEG_CYC)
	) u_bk_dg (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_level(lv[`MDFM_LV_BK_OC]),
		.o_level(bk_dg)
	);

	// a short low on the sleep pin is only a glitch, not a reset pulse
	mdfm_deglitch #(
		.N(RST_CYC)
	) u_sl_dg (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_level(!lv[`MDFM_LV_SLEEP_N]),
		.o_level(sl_long)
	);

	// *****************************
	// next state
	// *****************************
	logic supply_uv;
	logic sleep_pulse;
	logic clr;
	logic hw;
	logic ov_en_eff;
	logic ov_trip;
	logic [1:0] ocm_eff;
	logic tsd;
	logic tw_report;
	logic ser_event;
	logic oc_event;
	logic bk_start;
	logic report;

	always_comb begin
		s_nxt = s_r;
		hw = lv[`MDFM_LV_HW_VAR];
		supply_uv = lv[`MDFM_LV_MOT_UV] | lv[`MDFM_LV_ANA_UV];
		sleep_pulse = s_r.sl_long_q & !sl_long;
		// flags cleared by command or reset pulse from the controller
		clr = (i_wr && i_addr == `MDFM_ADDR_CTRL && i_wdata[`MDFM_CT_CLR])
			|| sleep_pulse;
		ov_en_eff = hw | s_r.ov_en;
		ov_trip = ov_en_eff & ((hw | s_r.ov_sel) ?
			lv[`MDFM_LV_OV_HI] : lv[`MDFM_LV_OV_LO]);
		ocm_eff = hw ? `MDFM_OCM_LATCH : s_r.ocm;
		tsd = lv[`MDFM_LV_TSD_FET] | lv[`MDFM_LV_TSD_DIE];
		tw_report = lv[`MDFM_LV_TW] & s_r.tw_rep;
		ser_event = i_serial_error & !s_r.ser_rep;
		oc_event = oc_dg && s_r.oc_st == MDFM_OC_IDLE
			&& ocm_eff != `MDFM_OCM_OFF;
		bk_start = bk_dg & !s_r.bk_act;
		s_nxt.sl_long_q = sl_long;

		// control register write
		if (i_wr && i_addr == `MDFM_ADDR_CTRL) begin
			s_nxt.ov_en = i_wdata[`MDFM_CT_OV_EN];
			s_nxt.ov_sel = i_wdata[`MDFM_CT_OV_SEL];
			s_nxt.ocm = i_wdata[`MDFM_CT_OCM_HI:`MDFM_CT_OCM_LO];
			s_nxt.ser_rep = i_wdata[`MDFM_CT_SER_REP];
			s_nxt.tw_rep = i_wdata[`MDFM_CT_TW_REP];
		end

		// clears first, so a set in the same cycle wins
		if (clr) begin
			s_nxt.f_fault = 1'b0;
			s_nxt.f_por = 1'b1;
			s_nxt.f_bk_uv = 1'b0;
			s_nxt.f_bk_sum = s_r.bk_act;
			s_nxt.f_cp_uv = 1'b0;
			s_nxt.f_ov = 1'b0;
			s_nxt.f_oc = 1'b0;
			s_nxt.f_ser = 1'b0;
			s_nxt.f_ts = 1'b0;
			s_nxt.f_tw = lv[`MDFM_LV_TW];
		end
		if (sleep_pulse) begin
			s_nxt.f_trim = 1'b0;
		end

		// *****************************
		// voltage faults
		// *****************************
		if (supply_uv) begin
			s_nxt.f_por = 1'b0;
		end
		if (lv[`MDFM_LV_BK_UV]) begin
			s_nxt.f_bk_uv = 1'b1;
			s_nxt.f_bk_sum = 1'b1;
			s_nxt.f_fault = 1'b1;
		end
		// no control bit reaches this branch
		if (lv[`MDFM_LV_CP_UV]) begin
			s_nxt.f_cp_uv = 1'b1;
			s_nxt.f_fault = 1'b1;
		end
		if (ov_trip) begin
			s_nxt.f_ov = 1'b1;
			s_nxt.f_fault = 1'b1;
		end

		// *****************************
		// phase overcurrent
		// *****************************
		unique case (s_r.oc_st)
			MDFM_OC_IDLE: begin
				if (oc_event) begin
					s_nxt.f_oc = 1'b1;
					s_nxt.f_fault = 1'b1;
					s_nxt.oc_cnt = '0;
					unique case (ocm_eff)
						`MDFM_OCM_LATCH: s_nxt.oc_st = MDFM_OC_LATCH;
						`MDFM_OCM_RETRY: s_nxt.oc_st = MDFM_OC_RETRY;
						default: s_nxt.oc_st = MDFM_OC_REPORT;
					endcase
				end
			end
			MDFM_OC_LATCH, MDFM_OC_REPORT: begin
				if (clr && !oc_dg) begin
					s_nxt.oc_st = MDFM_OC_IDLE;
				end
			end
			MDFM_OC_RETRY: begin
				if (s_r.oc_cnt == RETRY_LAST) begin
					s_nxt.oc_st = MDFM_OC_IDLE;
				end else begin
					s_nxt.oc_cnt = s_r.oc_cnt + mdfm_cnt_t'(1);
				end
			end
		endcase

		// *****************************
		// buck overcurrent
		// *****************************
		if (bk_start) begin
			s_nxt.bk_act = 1'b1;
			s_nxt.bk_cnt = '0;
			s_nxt.f_bk_oc = 1'b1;
			s_nxt.f_bk_sum = 1'b1;
			s_nxt.f_fault = 1'b1;
		end else if (s_r.bk_act) begin
			if (s_r.bk_cnt == BK_RETRY_LAST) begin
				s_nxt.bk_act = 1'b0;
				s_nxt.f_bk_oc = 1'b0;
				s_nxt.f_bk_sum = s_nxt.f_bk_uv;
			end else begin
				s_nxt.bk_cnt = s_r.bk_cnt + mdfm_cnt_t'(1);
			end
		end

		// *****************************
		// other faults
		// *****************************
		if (ser_event) begin
			s_nxt.f_ser = 1'b1;
			s_nxt.f_fault = 1'b1;
		end
		if (i_trim_error) begin
			s_nxt.f_trim = 1'b1;
			s_nxt.f_fault = 1'b1;
		end
		if (lv[`MDFM_LV_TW]) begin
			s_nxt.f_tw = 1'b1;
		end
		if (tw_report) begin
			s_nxt.f_fault = 1'b1;
		end
		if (tsd) begin
			s_nxt.f_ts = 1'b1;
			s_nxt.f_fault = 1'b1;
		end

		// *****************************
		// outputs
		// *****************************
		report = lv[`MDFM_LV_BK_UV] | lv[`MDFM_LV_CP_UV] | ov_trip
			| (s_r.oc_st != MDFM_OC_IDLE) | s_r.bk_act | s_r.f_ser
			| s_r.f_trim | tw_report | tsd;
		s_nxt.fault_n = !report;
		s_nxt.bridge_hiz = supply_uv | lv[`MDFM_LV_CP_UV] | ov_trip
			| s_r.oc_st == MDFM_OC_LATCH | s_r.oc_st == MDFM_OC_RETRY
			| s_r.f_trim | tsd | !lv[`MDFM_LV_SLEEP_N];
		s_nxt.pump_en = !supply_uv & !tsd & lv[`MDFM_LV_SLEEP_N];
		s_nxt.logic_en = !supply_uv;
		s_nxt.buck_en = !s_r.bk_act & !lv[`MDFM_LV_TSD_DIE]
			& lv[`MDFM_LV_SLEEP_N];

		// read data stands one cycle only
		s_nxt.rdata = '0;
		if (i_rd) begin
			unique case (i_addr)
				`MDFM_ADDR_STATUS: begin
					s_nxt.rdata[`MDFM_ST_FAULT] = s_r.f_fault;
					s_nxt.rdata[`MDFM_ST_POR] = s_r.f_por;
					s_nxt.rdata[`MDFM_ST_BK_SUM] = s_r.f_bk_sum;
					s_nxt.rdata[`MDFM_ST_BK_UV] = s_r.f_bk_uv;
					s_nxt.rdata[`MDFM_ST_CP_UV] = s_r.f_cp_uv;
					s_nxt.rdata[`MDFM_ST_OV] = s_r.f_ov;
					s_nxt.rdata[`MDFM_ST_OC] = s_r.f_oc;
					s_nxt.rdata[`MDFM_ST_BK_OC] = s_r.f_bk_oc;
					s_nxt.rdata[`MDFM_ST_SER] = s_r.f_ser;
					s_nxt.rdata[`MDFM_ST_TW] = s_r.f_tw;
					s_nxt.rdata[`MDFM_ST_TS] = s_r.f_ts;
					s_nxt.rdata[`MDFM_ST_TRIM] = s_r.f_trim;
				end
				`MDFM_ADDR_CTRL: begin
					s_nxt.rdata[`MDFM_CT_OV_EN] = s_r.ov_en;
					s_nxt.rdata[`MDFM_CT_OV_SEL] = s_r.ov_sel;
					s_nxt.rdata[`MDFM_CT_OCM_HI:`MDFM_CT_OCM_LO] = s_r.ocm;
					s_nxt.rdata[`MDFM_CT_SER_REP] = s_r.ser_rep;
					s_nxt.rdata[`MDFM_CT_TW_REP] = s_r.tw_rep;
				end
				`MDFM_ADDR_LIVE: begin
					s_nxt.rdata[`MDFM_NSYNC-1:0] = lv;
				end
				default: begin
					s_nxt.rdata = '0;
				end
			endcase
		end
	end

	// *****************************
	// registers
	// *****************************
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_r <= '0;
			s_r.ocm <= `MDFM_OCM_LATCH;
			s_r.fault_n <= 1'b1;
			s_r.bridge_hiz <= 1'b1;
			s_r.oc_st <= MDFM_OC_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_rdata = s_r.rdata;
	assign o_fault_pin_n = s_r.fault_n;
	assign o_bridge_hiz = s_r.bridge_hiz;
	assign o_pump_en = s_r.pump_en;
	assign o_logic_en = s_r.logic_en;
	assign o_buck_en = s_r.buck_en;
endmodule

/* testbench/mdfm_ctl_model.sv */
// controller model: register port master and sleep pin
`timescale 1ns/1ps
module mdfm_ctl_model (
	// clock and read data
	input wire logic i_clk,
	input wire mdfm_pkg::mdfm_data_t i_rdata,
	// register port
	output mdfm_pkg::mdfm_addr_t o_addr,
	output mdfm_pkg::mdfm_data_t o_wdata,
	output logic o_wr,
	output logic o_rd,
	// sleep pin, active low
	output logic o_sleep_pin_n
);
	import mdfm_pkg::*;
	initial begin
		o_addr = '0;
		o_wdata = '0;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_sleep_pin_n = 1'b1;
	end
	task automatic wr(input mdfm_addr_t a, input mdfm_data_t v);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= v;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
	endtask
	// data taken in the one cycle it stands
	task automatic rd(input mdfm_addr_t a, output mdfm_data_t v);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		@(posedge i_clk);
		v = i_rdata;
	endtask
	// n must cover the reset pulse count
	task automatic sleep_pulse(input int n);
		@(posedge i_clk);
		o_sleep_pin_n <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_sleep_pin_n <= 1'b1;
	endtask
endmodule

/* testbench/mdfm_checker_properties.sv */
// port assertions of the fault manager
`timescale 1ns/1ps
`include "mdfm_cfg.svh"
module mdfm_checker #(
	parameter int BK_DEG_CYC = 24
) (
	// clock, reset, register writes
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire mdfm_pkg::mdfm_addr_t i_addr,
	input wire mdfm_pkg::mdfm_data_t i_wdata,
	input wire logic i_wr,
	// conditions
	input wire logic i_motor_supply_uv,
	input wire logic i_analog_rail_uv,
	input wire logic i_buck_undervolt_flag,
	input wire logic i_pump_output_uv,
	input wire logic i_overvolt_low_trip,
	input wire logic i_overvolt_high_trip,
	input wire logic i_buck_overcurrent,
	input wire logic i_fet_area_thermal_shutdown,
	input wire logic i_die_thermal_shutdown,
	input wire logic i_sleep_pin_n,
	input wire logic i_hw_variant,
	input wire logic i_serial_error,
	input wire logic i_trim_error,
	// outputs
	input wire logic o_fault_pin_n,
	input wire logic o_bridge_hiz,
	input wire logic o_pump_en,
	input wire logic o_logic_en,
	input wire logic o_buck_en
);
	import mdfm_pkg::*;
	logic [5:0] ctl_r;
	logic [7:0] bk_run_r;
	logic quiet;
	logic ov_arm;
	// supply loss or sleep may mask the pin, so those are left out
	assign quiet = !i_motor_supply_uv && !i_analog_rail_uv && i_sleep_pin_n;
	assign ov_arm = quiet && (i_overvolt_high_trip && (i_hw_variant ||
		ctl_r[0] && ctl_r[1]) || i_overvolt_low_trip && !i_hw_variant &&
		ctl_r[0] && !ctl_r[1]);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// shadow of the control word, since it is not visible at the ports
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctl_r <= 6'h00;
			bk_run_r <= 8'h00;
		end else begin
			if (i_wr && i_addr == `MDFM_ADDR_CTRL)
				ctl_r <= i_wdata[5:0];
			bk_run_r <= i_buck_overcurrent ?
				bk_run_r + 8'(bk_run_r != 8'hff) : 8'h00;
		end
	end
	mot_uv_a: assert property (i_motor_supply_uv [*4] |->
		o_bridge_hiz && !o_pump_en && !o_logic_en) else $error("supply uv");
	ana_uv_a: assert property (i_analog_rail_uv [*4] |->
		o_bridge_hiz && !o_pump_en && !o_logic_en) else $error("analog uv");
	buck_undervolt_flag_a: assert property ((i_buck_undervolt_flag && quiet) [*4] |->
		!o_fault_pin_n && o_logic_en) else $error("buck_undervolt_flag");
	pump_uv_a: assert property ((i_pump_output_uv && quiet) [*4] |->
		o_bridge_hiz && !o_fault_pin_n) else $error("pump uv");
	ov_trip_a: assert property (ov_arm [*4] |->
		o_bridge_hiz && !o_fault_pin_n) else $error("overvoltage");
	trim_hold_a: assert property (i_sleep_pin_n [*4] ##0
		(i_trim_error && quiet) |-> ##2 (o_bridge_hiz && !o_fault_pin_n) [*5])
		else $error("trim error");
	ser_err_a: assert property (i_serial_error && !ctl_r[4] &&
		quiet && !i_hw_variant |=> ##1 !o_fault_pin_n) else $error("serial");
	tsd_off_a: assert property ((i_fet_area_thermal_shutdown ||
		i_die_thermal_shutdown) [*4] |-> o_bridge_hiz && !o_pump_en)
		else $error("thermal shutdown");
	bk_oc_a: assert property (bk_run_r == 8'(BK_DEG_CYC + 8) |->
		!o_buck_en) else $error("buck overcurrent");
	cover property (i_trim_error);
	cover property (ov_arm [*4]);
	cover property (bk_run_r == 8'h20);
endmodule
bind mdfm_top mdfm_checker #(.BK_DEG_CYC(BK_DEG_CYC)) chk (.*);

/* testbench/testbench.sv */
// self-checking bench of the fault manager
`timescale 1ns/1ps
`include "mdfm_cfg.svh"
module testbench;
	import mdfm_pkg::*;
	// outputs order: fault_n, hiz, pump, logic, buck
	typedef struct packed {
		logic [10:0] c;
		logic [5:0] k;
		logic [4:0] e;
		logic [4:0] m;
		logic an;
		logic [3:0] b;
		logic sv;
	} mdfm_row_t;
	mdfm_row_t rows [17] = '{
		'{11'h001, 6'h00, 5'h18, 5'h1e, 1'b1, 4'h1, 1'b0},
		'{11'h002, 6'h00, 5'h18, 5'h1e, 1'b1, 4'h1, 1'b0},
		'{11'h004, 6'h00, 5'h06, 5'h1e, 1'b1, 4'h3, 1'b1},
		'{11'h008, 6'h3f, 5'h0a, 5'h1a, 1'b1, 4'h4, 1'b1},
		'{11'h030, 6'h03, 5'h0a, 5'h1a, 1'b1, 4'h5, 1'b1},
		'{11'h010, 6'h01, 5'h0a, 5'h1a, 1'b1, 4'h5, 1'b1},
		'{11'h030, 6'h00, 5'h17, 5'h1f, 1'b1, 4'h5, 1'b0},
		'{11'h010, 6'h03, 5'h10, 5'h18, 1'b1, 4'h5, 1'b0},
		'{11'h040, 6'h00, 5'h0a, 5'h1a, 1'b0, 4'h6, 1'b1},
		'{11'h040, 6'h04, 5'h0a, 5'h1a, 1'b1, 4'h6, 1'b1},
		'{11'h040, 6'h08, 5'h06, 5'h1e, 1'b0, 4'h6, 1'b1},
		'{11'h040, 6'h0c, 5'h10, 5'h18, 1'b1, 4'h6, 1'b0},
		'{11'h080, 6'h00, 5'h06, 5'h1f, 1'b1, 4'h7, 1'b0},
		'{11'h100, 6'h00, 5'h10, 5'h18, 1'b1, 4'h9, 1'b1},
		'{11'h100, 6'h20, 5'h00, 5'h18, 1'b1, 4'h9, 1'b1},
		'{11'h200, 6'h00, 5'h08, 5'h1c, 1'b1, 4'ha, 1'b1},
		'{11'h400, 6'h00, 5'h08, 5'h1d, 1'b1, 4'ha, 1'b1}
	};
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_hw_variant = 1'b0;
	logic i_serial_error = 1'b0;
	logic i_trim_error = 1'b0;
	logic [10:0] c = 11'h000;
	logic i_motor_supply_uv, i_analog_rail_uv, i_buck_undervolt_flag, i_pump_output_uv;
	logic i_overvolt_low_trip, i_overvolt_high_trip, i_phase_overcurrent;
	logic i_buck_overcurrent, i_thermal_warning;
	logic i_fet_area_thermal_shutdown, i_die_thermal_shutdown;
	logic i_wr, i_rd, i_sleep_pin_n;
	logic o_fault_pin_n, o_bridge_hiz, o_pump_en, o_logic_en, o_buck_en;
	logic [4:0] outs;
	mdfm_addr_t i_addr;
	mdfm_data_t i_wdata, o_rdata, d;
	int n_mismatch = 0;
	int samples_checked = 0;
	assign {i_die_thermal_shutdown, i_fet_area_thermal_shutdown,
		i_thermal_warning, i_buck_overcurrent, i_phase_overcurrent,
		i_overvolt_high_trip, i_overvolt_low_trip, i_pump_output_uv,
		i_buck_undervolt_flag, i_analog_rail_uv, i_motor_supply_uv} = c;
	assign outs = {o_fault_pin_n, o_bridge_hiz, o_pump_en, o_logic_en, o_buck_en};
	always #12.5 i_clk = ~i_clk;
	mdfm_ctl_model ctl (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
		.o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd),
		.o_sleep_pin_n(i_sleep_pin_n));
	// short retry and pulse counts keep the run brief
	mdfm_top #(.RST_CYC(4), .RETRY_CYC(20), .BK_RETRY_CYC(20)) dut (.*);
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic pin(input logic [1:0] exp);
		cmp({14'h0, o_fault_pin_n, o_bridge_hiz}, {14'h0, exp});
	endtask
	task automatic st(input int b, input logic v);
		ctl.rd(`MDFM_ADDR_STATUS, d);
		cmp({15'h0, d[b]}, {15'h0, v});
	endtask
	task automatic clr(input logic [5:0] k);
		ctl.wr(`MDFM_ADDR_CTRL, {9'h000, 1'b1, k});
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		cyc(20000);
		n_mismatch++;
		end_of_test;
	end
	initial begin
		cyc(8);
		cmp({11'h0, outs}, 16'h0018);
		i_reset_n <= 1'b1;
		ctl.rd(`MDFM_ADDR_STATUS, d);
		cmp(d, 16'h0000);
		ctl.rd(`MDFM_ADDR_CTRL, d);
		cmp(d, `MDFM_CTRL_RST);
		ctl.rd(4'hc, d);
		cmp(d, 16'h0000);
		foreach (rows[i]) begin
			ctl.wr(`MDFM_ADDR_CTRL, {10'h000, rows[i].k});
			c <= rows[i].c;
			cyc(36);
			cmp({11'h0, outs & rows[i].m}, {11'h0, rows[i].e & rows[i].m});
			ctl.rd(`MDFM_ADDR_LIVE, d);
			cmp({3'h0, d[12:0]}, {5'h01, rows[i].c});
			c <= 11'h000;
			cyc(60);
			cmp({15'h0, o_fault_pin_n}, {15'h0, rows[i].an});
			st(rows[i].b, rows[i].sv);
			clr(rows[i].k);
			cyc(8);
			st(rows[i].b, rows[i].b == 4'h1);
			pin(2'b10);
		end
		// burst shorter than the deglitch time
		c <= 11'h040;
		cyc(10);
		c <= 11'h000;
		cyc(40);
		pin(2'b10);
		st(`MDFM_ST_OC, 1'b0);
		// latched mode: a clear while the condition stands clears the flags but leaves the pins latched
		c <= 11'h040;
		cyc(36);
		clr(6'h00);
		cyc(4);
		pin(2'b01);
		c <= 11'h000;
		cyc(8);
		pin(2'b01);
		clr(6'h00);
		cyc(4);
		pin(2'b10);
		c <= 11'h004;
		cyc(8);
		c <= 11'h000;
		cyc(8);
		ctl.rd(`MDFM_ADDR_STATUS, d);
		cmp(d & 16'h000d, 16'h000d);
		i_serial_error <= 1'b1;
		cyc(1);
		i_serial_error <= 1'b0;
		cyc(4);
		pin(2'b00);
		st(`MDFM_ST_SER, 1'b1);
		clr(6'h10);
		cyc(4);
		i_serial_error <= 1'b1;
		cyc(1);
		i_serial_error <= 1'b0;
		cyc(4);
		pin(2'b10);
		i_trim_error <= 1'b1;
		cyc(1);
		i_trim_error <= 1'b0;
		cyc(4);
		pin(2'b01);
		clr(6'h00);
		cyc(8);
		pin(2'b01);
		st(`MDFM_ST_TRIM, 1'b1);
		ctl.sleep_pulse(8);
		cyc(12);
		pin(2'b10);
		st(`MDFM_ST_TRIM, 1'b0);
		i_hw_variant <= 1'b1;
		c <= 11'h010;
		cyc(12);
		pin(2'b10);
		c <= 11'h030;
		cyc(12);
		pin(2'b01);
		c <= 11'h000;
		i_hw_variant <= 1'b0;
		cyc(8);
		clr(6'h00);
		cyc(8);
		pin(2'b10);
		end_of_test;
	end
endmodule
